// >>> logic/bcwl_defines.vh
// Constants for the boot configuration window loader
`ifndef BCWL_DEFINES_VH
`define BCWL_DEFINES_VH
`define BCWL_WIN_FIRST    16'h7800
`define BCWL_WIN_LAST     16'h7827
`define BCWL_PAGE0_BASE   16'h7800
`define BCWL_PAGE1_BASE   16'h7808
`define BCWL_PAGE2_BASE   16'h7810
`define BCWL_PAGE3_BASE   16'h7818
`define BCWL_PAGE4_BASE   16'h7820
`define BCWL_TAG_WORD     16'h7810
`define BCWL_CHECK_WORD   16'h7827
`define BCWL_CTRL_ADDR    16'h7F00
`define BCWL_STAT_ADDR    16'h7F01
`define BCWL_CHECK_VALUE  16'hA596
`define BCWL_WORD_RESET   16'h0000
`define BCWL_AUTOBURN_BIT 15
`define BCWL_TAG_HI       14
`define BCWL_TAG_LO       1
`define BCWL_LOCK_BIT     0
`define BCWL_EE_P2_BASE   8'h00
`define BCWL_EE_P3_BASE   8'h10
`define BCWL_EE_P4_BASE   8'h20
`define BCWL_CMD_NVREAD   0
`define BCWL_CMD_NVWRITE  1
`define BCWL_CMD_EEREAD   2
`define BCWL_CMD_PAGE     3
`define BCWL_ST_DONE      0
`define BCWL_ST_ERR       1
`define BCWL_ST_BUSY      2
`define BCWL_ST_HALT      3
`define BCWL_ST_READY     4
`endif

// >>> logic/bcwl_loader.v
// Boot configuration window loader: window store, load, burn and verify
//
// Our own choice: the address-and-strobe port.
`include "bcwl_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module bcwl_loader #(
  parameter WORDS = 40                 // Window depth in words
) (
  input  wire        mclk,             // System clock, 50 MHz
  input  wire        sys_rst,          // Async reset, active high
  input  wire [15:0] regAddr,          // Register word address
  input  wire [15:0] regWdata,         // Register write data
  input  wire        regWr,            // Write strobe
  input  wire        regRd,            // Read strobe
  output reg  [15:0] regRdata,         // Read data, cycle after strobe
  input  wire        onRequest,        // ON transition scheduled, pulse
  input  wire        devMode,          // Development mode strap level
  input  wire        reloadOnPowerUp,  // Reload user pages at ON
  output reg         configReady,      // Window loaded and valid
  output reg         stayOff,          // Image rejected, hold OFF
  output reg  [1:0]  nvPage,           // One-time memory page select
  output reg  [2:0]  nvWordSel,        // Word within page
  output reg         nvRdReq,          // One-time memory read request
  output reg         nvWrReq,          // One-time memory program request
  output reg         nvMargin1,        // Read at first margin level
  output reg  [15:0] nvWdata,          // Program data
  input  wire [15:0] nvRdata,          // Read data, valid with ack
  input  wire        nvAck,            // Memory access done
  input  wire        nvLockedIn,       // Lock bit as held in memory
  output reg  [7:0]  eeAddr,           // EEPROM byte address
  output reg         eeRdReq,          // EEPROM byte read request
  input  wire [7:0]  eeRdata,          // EEPROM byte data
  input  wire        eeAck,            // EEPROM byte done
  output reg  [1:0]  statusLed         // LED1/LED2 burn indication
);
  // One-hot sequencer states
  localparam S_IDLE   = 7'b0000001;
  localparam S_NVRD   = 7'b0000010;
  localparam S_EERD   = 7'b0000100;
  localparam S_CHECK  = 7'b0001000;
  localparam S_BURN   = 7'b0010000;
  localparam S_VERIFY = 7'b0100000;
  localparam S_HALT   = 7'b1000000;

  reg [15:0] win_q [0:WORDS-1];        // Window storage, all power-up fields
  reg [6:0]  state_q;                  // Sequencer state
  reg [5:0]  idx_q;                    // Word index being moved
  reg [5:0]  lastIdx_q;                // Final word index of run
  reg        lowByte_q;                // Odd EEPROM byte next
  reg        atOn_q;                   // Run started by ON request
  reg        autoRun_q;                // Auto burn in progress
  reg        cmdDone_q;                // Command-done sticky flag
  reg        cmdErr_q;                 // Command error sticky flag
  reg        burnLed_q;                // Burn finished indication
  reg [1:0]  cmdPage_q;                // Page of software command
  reg        nvReqOut_q;               // Request already issued

  wire       inWin  = (regAddr >= `BCWL_WIN_FIRST) &&
                      (regAddr <= `BCWL_WIN_LAST);
  wire [5:0] wIdx   = regAddr[5:0];
  wire [5:0] tagIdx = 6'h10;
  wire [15:0] tagWord = win_q[tagIdx];
  wire       tagOk  = |tagWord[`BCWL_TAG_HI:`BCWL_TAG_LO];
  wire       lockBoth = tagWord[`BCWL_LOCK_BIT] & nvLockedIn;
  wire       checkOk = (win_q[6'h27] == `BCWL_CHECK_VALUE);
  wire       busy   = (state_q != S_IDLE) && (state_q != S_HALT);
  wire       ctrlWr = regWr && (regAddr == `BCWL_CTRL_ADDR) && !busy;
  wire       statWr = regWr && (regAddr == `BCWL_STAT_ADDR);

  // Register read path, answered one cycle after the strobe
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      if (inWin) begin
        regRdata <= win_q[wIdx];     // Single storage per field
      end else if (regAddr == `BCWL_STAT_ADDR) begin
        regRdata <= {11'h000, configReady, stayOff, busy,
                     cmdErr_q, cmdDone_q};
      end else begin
        regRdata <= 16'h0000;        // Unmapped reads zero
      end
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // Window store: software writes to pages 2 to 4, loader fills pages 0/1 and, by mode, 2/3 or 2 to 4
  integer i;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        win_q[i] <= `BCWL_WORD_RESET;   // Tag word resets zero
      end
    end else begin
      if (regWr && inWin && !busy && wIdx >= 6'h10) begin
        win_q[wIdx] <= regWdata;        // Pages 0/1 not writable
      end
      if (state_q == S_NVRD && nvAck) begin
        win_q[idx_q] <= nvRdata;        // Memory copy
      end
      if (state_q == S_EERD && eeAck) begin
        if (!lowByte_q) begin
          win_q[idx_q][15:8] <= eeRdata; // Even byte high half
        end else begin
          win_q[idx_q][7:0] <= eeRdata;  // Odd byte low half
        end
      end
    end
  end

  // Sequencer: loads, checks, burn and verify
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= S_IDLE;
      idx_q       <= 6'h00;
      lastIdx_q   <= 6'h00;
      lowByte_q   <= 1'b0;
      atOn_q      <= 1'b0;
      autoRun_q   <= 1'b0;
      cmdDone_q   <= 1'b0;
      cmdErr_q    <= 1'b0;
      burnLed_q   <= 1'b0;
      configReady <= 1'b0;
      stayOff     <= 1'b0;
      cmdPage_q   <= 2'b00;
      nvReqOut_q  <= 1'b0;
    end else begin
      // Software clears flags by writing one; a set below wins
      if (statWr) begin
        cmdDone_q <= cmdDone_q & ~regWdata[`BCWL_ST_DONE];
        cmdErr_q  <= cmdErr_q & ~regWdata[`BCWL_ST_ERR];
      end
      case (state_q)
        S_IDLE: begin
          nvReqOut_q <= 1'b0;
          if (onRequest) begin
            configReady <= 1'b0;
            atOn_q      <= 1'b1;
            autoRun_q   <= 1'b0;
            idx_q       <= 6'h00;     // Page 0 first
            // Factory pages always; user pages only in normal reload
            lastIdx_q   <= (!devMode && reloadOnPowerUp) ?
                           6'h1F : 6'h0F;
            state_q     <= S_NVRD;
          end else if (ctrlWr && (regWdata[`BCWL_CMD_NVREAD] ||
                       regWdata[`BCWL_CMD_EEREAD])) begin
            atOn_q    <= 1'b0;
            cmdPage_q <= regWdata[`BCWL_CMD_PAGE+1:`BCWL_CMD_PAGE];
            idx_q     <= regWdata[`BCWL_CMD_PAGE] ? 6'h18 : 6'h10;
            lastIdx_q <= regWdata[`BCWL_CMD_PAGE] ? 6'h1F : 6'h17;
            lowByte_q <= 1'b0;
            state_q   <= regWdata[`BCWL_CMD_EEREAD] ? S_EERD
                                                    : S_NVRD;
          end else if (ctrlWr && regWdata[`BCWL_CMD_NVWRITE]) begin
            atOn_q <= 1'b0;
            if (lockBoth) begin
              cmdErr_q  <= 1'b1;      // Write ignored when locked
              cmdDone_q <= 1'b1;
            end else begin
              idx_q     <= regWdata[`BCWL_CMD_PAGE] ? 6'h18 : 6'h10;
              lastIdx_q <= regWdata[`BCWL_CMD_PAGE] ? 6'h1F : 6'h17;
              state_q   <= S_BURN;
            end
          end
        end
        S_NVRD: begin
          nvReqOut_q <= ~nvAck;
          if (nvAck) begin
            if (idx_q == lastIdx_q) begin
              nvReqOut_q <= 1'b0;
              if (atOn_q && devMode && reloadOnPowerUp) begin
                idx_q     <= 6'h10;   // Then EEPROM image
                lastIdx_q <= 6'h27;   // Through check word page
                lowByte_q <= 1'b0;
                state_q   <= S_EERD;
              end else if (atOn_q) begin
                state_q <= S_CHECK;
              end else begin
                cmdDone_q <= 1'b1;
                state_q   <= S_IDLE;
              end
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        S_EERD: begin
          if (eeAck) begin
            lowByte_q <= ~lowByte_q;
            if (lowByte_q) begin
              if (idx_q == lastIdx_q) begin
                if (atOn_q) begin
                  state_q <= S_CHECK;
                end else begin
                  cmdDone_q <= 1'b1;
                  state_q   <= S_IDLE;
                end
              end else begin
                idx_q <= idx_q + 6'h01;
              end
            end
          end
        end
        S_CHECK: begin
          if (!tagOk || (devMode && reloadOnPowerUp && !checkOk)) begin
            stayOff <= 1'b1;          // Hold OFF until reset
            state_q <= S_HALT;
          end else if (devMode && reloadOnPowerUp &&
                       tagWord[`BCWL_AUTOBURN_BIT] && !lockBoth) begin
            autoRun_q <= 1'b1;
            idx_q     <= 6'h10;
            lastIdx_q <= 6'h1F;
            state_q   <= S_BURN;
          end else begin
            configReady <= 1'b1;      // Only after loads and
            state_q     <= S_IDLE;
          end
        end
        S_BURN: begin
          nvReqOut_q <= ~nvAck;
          if (nvAck) begin
            nvReqOut_q <= 1'b0;
            if (idx_q == lastIdx_q) begin
              idx_q   <= autoRun_q ? 6'h10 : idx_q;
              state_q <= autoRun_q ? S_VERIFY : S_IDLE;
              if (!autoRun_q) begin
                cmdDone_q <= 1'b1;
              end
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        S_VERIFY: begin
          nvReqOut_q <= ~nvAck;
          if (nvAck) begin
            nvReqOut_q <= 1'b0;
            if (nvRdata != win_q[idx_q]) begin
              cmdErr_q <= 1'b1;       // Margin read mismatch
            end
            if (idx_q == lastIdx_q) begin
              cmdDone_q   <= 1'b1;
              burnLed_q   <= 1'b1;
              autoRun_q   <= 1'b0;
              configReady <= 1'b1;
              state_q     <= S_IDLE;
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        S_HALT: begin
          state_q <= S_HALT;          // Only a reset leaves
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Memory and EEPROM request drive, registered
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nvPage    <= 2'b00;
      nvWordSel <= 3'b000;
      nvRdReq   <= 1'b0;
      nvWrReq   <= 1'b0;
      nvMargin1 <= 1'b0;
      nvWdata   <= 16'h0000;
      eeAddr    <= 8'h00;
      eeRdReq   <= 1'b0;
      statusLed <= 2'b00;
    end else begin
      nvPage    <= idx_q[4:3];
      nvWordSel <= idx_q[2:0];
      // Level requests, dropped on the acknowledge
      nvRdReq   <= (state_q == S_NVRD || state_q == S_VERIFY) && !nvAck;
      nvWrReq   <= (state_q == S_BURN) && !nvAck;
      nvMargin1 <= (state_q == S_VERIFY);
      // Lock bit carried from the image into memory
      nvWdata   <= win_q[idx_q];
      eeAddr    <= {1'b0, idx_q[5:0] - 6'h10, lowByte_q};
      eeRdReq   <= (state_q == S_EERD) && !eeAck;
      statusLed <= {2{burnLed_q}};
    end
  end
endmodule // bcwl_loader
`default_nettype wire

// >>> bench/bcwl_partner_model.sv
// Behavioural one-time memory and configuration EEPROM
`timescale 1ns/10ps
`default_nettype none
module bcwl_partner_model (
  input  wire logic        mclk,       // System clock
  input  wire logic [3:0]  lat,        // Extra answer delay
  input  wire logic [1:0]  nvPage,     // Page select
  input  wire logic [2:0]  nvWordSel,  // Word select
  input  wire logic        nvRdReq,    // Read request
  input  wire logic        nvWrReq,    // Program request
  input  wire logic [15:0] nvWdata,    // Program data
  output var  logic [15:0] nvRdata,    // Read data
  output var  logic        nvAck,      // Word done
  output logic             nvLockedIn, // Stored lock bit
  input  wire logic [7:0]  eeAddr,     // Byte address
  input  wire logic        eeRdReq,    // Byte request
  output var  logic [7:0]  eeRdata,    // Byte data
  output var  logic        eeAck       // Byte done
);
  logic [15:0] nv [32];  // Four pages of eight words
  logic [7:0]  ee [48];  // Three byte pages
  logic [3:0]  nvCnt;    // Memory wait count
  logic [3:0]  eeCnt;    // EEPROM wait count
  assign nvLockedIn = nv[16][0]; // Lock lives in page 2 word 0
  initial begin
    for (int i = 0; i < 32; i++) nv[i] = 16'h3000 + 16'(2 * i);
    for (int i = 0; i < 48; i++) ee[i] = 8'h40 + 8'(i);
    {nvCnt, eeCnt, nvAck, eeAck, nvRdata, eeRdata} = '0;
  end
  // Memory: data only with ack, toggling junk otherwise
  always @(posedge mclk) begin
    if (!(nvRdReq || nvWrReq) || nvAck) begin
      nvCnt <= 4'h0;
      nvAck <= 1'b0;
      nvRdata <= ~nvRdata;
    end else if (nvCnt == lat) begin
      nvAck <= 1'b1;
      nvRdata <= nv[{nvPage, nvWordSel}];
      // Fuses only ever set, as real cells do
      if (nvWrReq) nv[{nvPage, nvWordSel}] <= nv[{nvPage, nvWordSel}] | nvWdata;
    end else nvCnt <= nvCnt + 4'h1;
  end
  // EEPROM byte reads, same handshake
  always @(posedge mclk) begin
    if (!eeRdReq || eeAck) begin
      eeCnt <= 4'h0;
      eeAck <= 1'b0;
      eeRdata <= ~eeRdata;
    end else if (eeCnt == lat) begin
      eeAck <= 1'b1;
      eeRdata <= ee[eeAddr];
    end else eeCnt <= eeCnt + 4'h1;
  end
endmodule // bcwl_partner_model
`default_nettype wire

// >>> bench/bcwl_loader_assertions.sv
// Handshake and sequencing checks for the window loader
`timescale 1ns/10ps
`default_nettype none
module bcwl_loader_assertions (
  input wire logic       mclk,        // System clock
  input wire logic       sys_rst,     // Async reset
  input wire logic       configReady, // Loaded and valid
  input wire logic       stayOff,     // Held off
  input wire logic       nvRdReq,     // Memory read
  input wire logic       nvWrReq,     // Memory program
  input wire logic       nvMargin1,   // Margin read
  input wire logic       nvAck,       // Memory done
  input wire logic [7:0] eeAddr,      // EEPROM address
  input wire logic       eeRdReq,     // EEPROM request
  input wire logic       eeAck        // EEPROM done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Requests still waiting for an answer
  sequence nvWait; (nvRdReq || nvWrReq) && !nvAck; endsequence
  sequence eeWait; eeRdReq && !eeAck; endsequence
  chk_nv_req_held: assert property (nvWait |=> (nvRdReq || nvWrReq)
    && $stable(nvWrReq)) else $error("memory request dropped early");
  chk_nv_req_drop: assert property (nvAck |=> !nvRdReq && !nvWrReq)
    else $error("memory request held past ack");
  chk_ee_req_held: assert property (eeWait |=> eeRdReq
    && $stable(eeAddr)) else $error("EEPROM request changed early");
  chk_ee_req_drop: assert property (eeAck |=> !eeRdReq)
    else $error("EEPROM request held past ack");
  chk_ee_range: assert property (eeRdReq |-> eeAddr <= 8'h2F)
    else $error("EEPROM address outside image");
  chk_ready_quiet: assert property ($rose(configReady) |-> !nvRdReq
    && !nvWrReq && !eeRdReq) else $error("ready while loading");
  chk_off_excl: assert property (stayOff |-> !configReady)
    else $error("ready while held off");
  chk_off_sticky: assert property (stayOff |=> stayOff)
    else $error("held off released without reset");
  chk_margin_read: assert property (nvMargin1 && nvWrReq |-> 1'b0)
    else $error("margin level on a program access");
endmodule // bcwl_loader_assertions
bind bcwl_loader bcwl_loader_assertions u_chk (.*);
`default_nettype wire

// >>> bench/bcwl_loader_tb_top.sv
// Self-checking bench for the configuration window loader
`include "bcwl_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module bcwl_loader_tb_top;
  logic        mclk, sys_rst, regWr, regRd, onRequest;   // Bench drives
  logic        devMode, reloadOnPowerUp;                 // Straps
  logic [15:0] regAddr, regWdata, regRdata, got, k;      // Bus side
  logic [15:0] nvRdata, nvWdata;                         // Memory data
  logic        configReady, stayOff, nvRdReq, nvWrReq;   // Status, reqs
  logic        nvMargin1, nvAck, nvLockedIn, eeRdReq, eeAck;
  logic [1:0]  nvPage, statusLed;                        // Page, LEDs
  logic [2:0]  nvWordSel;                                // Word select
  logic [7:0]  eeAddr, eeRdata;                          // EEPROM bytes
  logic [3:0]  lat;                                      // Partner delay
  int          errTotal, checked;                        // Tallies
  bcwl_loader dut (.*);
  bcwl_partner_model pm (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    // Read data stands only in the cycle after the strobe
    #1 got = regRdata;
    cmp(e, got);
    @(posedge mclk);
  endtask
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask
  // ON pulse, then bounded wait for ready or held off
  task automatic power_on(input logic dm, input logic [3:0] l);
    devMode <= dm;
    lat <= l;
    onRequest <= 1'b1;
    @(posedge mclk);
    onRequest <= 1'b0;
    for (int i = 0; i < 3000 && configReady !== 1'b1
         && stayOff !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
    if (configReady !== 1'b1 && stayOff !== 1'b1) begin
      errTotal++;
      $display("MISMATCH t=%0t power-up wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // Clear flags, issue a command, poll done with a bound
  task automatic command(input logic [15:0] c);
    wr(`BCWL_STAT_ADDR, 16'h0003);
    wr(`BCWL_CTRL_ADDR, c);
    for (int i = 0; i < 300; i++) begin
      regAddr <= `BCWL_STAT_ADDR;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 got = regRdata;
      @(posedge mclk);
      if (got[`BCWL_ST_DONE] === 1'b1) return;
    end
    errTotal++;
    tally_and_finish();
  endtask
  initial begin
    {regWr, regRd, onRequest, devMode, regAddr, regWdata} = '0;
    {errTotal, checked, lat} = '0;
    reloadOnPowerUp = 1'b1;
    sys_rst = 1'b1;
    do_reset();
    chk(`BCWL_TAG_WORD, `BCWL_WORD_RESET);
    // Normal boot, slow memory
    power_on(1'b0, 4'h2);
    cmp(16'h0001, {15'h0, configReady});
    for (k = 0; k < 32; k = k + 7)
      chk(`BCWL_WIN_FIRST + k, 16'h3000 + k + k);
    wr(16'h7800, 16'hFFFF);
    chk(16'h7800, 16'h3000);
    wr(16'h780A, 16'hFFFF);
    chk(16'h780A, 16'h3014);
    wr(`BCWL_WIN_LAST, 16'h1234);
    chk(`BCWL_WIN_LAST, 16'h1234);
    wr(16'h7828, 16'h1234);
    chk(16'h7828, 16'h0000);
    wr(16'h7818, 16'h0BAD);
    command(16'h0009);
    chk(16'h7818, 16'h3030);
    // No reload: user pages stay zero, zero tag holds off
    do_reset();
    reloadOnPowerUp <= 1'b0;
    power_on(1'b0, 4'h0);
    cmp(16'h0001, {15'h0, stayOff});
    chk(`BCWL_TAG_WORD, 16'h0000);
    // Development image with a bad check word
    do_reset();
    reloadOnPowerUp <= 1'b1;
    pm.ee[0] = 8'h80;
    pm.ee[1] = 8'h03;
    power_on(1'b1, 4'h1);
    cmp(16'h0001, {15'h0, stayOff});
    chk(`BCWL_TAG_WORD, 16'h8003);
    chk(16'h7818, 16'h5051);
    cmp(16'h3020, pm.nv[16]);
    // Good image: burn, verify, lock
    do_reset();
    pm.ee[46] = 8'hA5;
    pm.ee[47] = 8'h96;
    for (int i = 16; i < 32; i++) pm.nv[i] = 16'h0000;
    power_on(1'b1, 4'h0);
    cmp(16'h0001, {15'h0, configReady});
    cmp(16'h8003, pm.nv[16]);
    cmp(16'h5E5F, pm.nv[31]);
    cmp(16'h0003, {14'h0, statusLed});
    chk(`BCWL_STAT_ADDR, 16'h0011);
    wr(16'h7811, 16'hFFFF);
    command(16'h0002);
    cmp(16'h4243, pm.nv[17]);
    chk(`BCWL_STAT_ADDR, 16'h0013);
    wr(16'h7818, 16'h0000);
    command(16'h000C);
    chk(16'h7818, 16'h5051);
    tally_and_finish();
  end
endmodule // bcwl_loader_tb_top
`default_nettype wire
